// file: hw/bfp_pkg.sv
package bfp_pkg;

    // ------------------------------------------------------------
    // flash geometry (word addresses)
    // ------------------------------------------------------------
    localparam int FLASH_AW = 14;
    localparam logic [FLASH_AW-1:0] APP_RESET_ADDR = 14'h0000;
    // start of the halting region; the loader section always lies inside it
    localparam logic [FLASH_AW-1:0] HALT_REGION_START = 14'h3800;
    // loader section size in words for each boot_size_select code
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_SEL0 = 14'h0800;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_SEL1 = 14'h0400;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_SEL2 = 14'h0200;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_SEL3 = 14'h0100;

    // ------------------------------------------------------------
    // lock field layout, 1 = unprogrammed, 0 = programmed
    // ------------------------------------------------------------
    localparam int LOCK_W = 4;
    localparam int LOCK_BOOT_WRITE = 0;
    localparam int LOCK_BOOT_READ = 1;
    localparam int LOCK_APP_WRITE = 2;
    localparam int LOCK_APP_READ = 3;
    localparam logic [LOCK_W-1:0] LOCK_ERASED = 4'hf;

    // fuse synchroniser layout
    localparam int FUSE_W = 3;
    localparam int FUSE_BOOT_RESET = 2;

    // ------------------------------------------------------------
    // core request kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BFP_REQ_LOAD = 3'h0,
        BFP_REQ_FILL = 3'h1,
        BFP_REQ_ERASE = 3'h2,
        BFP_REQ_WRITE = 3'h3,
        BFP_REQ_LOCK_SET = 3'h4,
        BFP_REQ_REGION_ENABLE = 3'h5
    } bfp_req_type;

endpackage : bfp_pkg

// file: hw/bfp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for static pin levels
module bfp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } bfp_sync_state_type;

    bfp_sync_state_type s_r;
    bfp_sync_state_type s_nxt;

    // meta feeds only the second stage
    always_comb begin
        s_nxt.meta = d_in;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '1; // fuses read unprogrammed until sampled
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.sync;
endmodule : bfp_sync

// file: hw/bfp_section.sv
`timescale 1ns/1ps
// classifies one word address into loader section and halting region
module bfp_section
    import bfp_pkg::*;
#(
    parameter int AW = FLASH_AW
) (
    input wire logic [AW-1:0] addr_in,
    input wire logic [AW-1:0] boot_start_in,
    input wire logic [AW-1:0] halt_start_in,
    output logic in_boot_out,
    output logic in_halting_out
);
    // plain comparisons against the configured boundaries
    always_comb begin
        in_boot_out = (addr_in >= boot_start_in);
        in_halting_out = (addr_in >= halt_start_in);
    end
endmodule : bfp_section

// file: hw/bfp_protect.sv
`timescale 1ns/1ps
// Overview of operation
// - programming the concurrent region keeps core running; halting region stays readable
// - programming the halting region halts the core; nothing readable meanwhile
// - lock bits only programmable by software or external programming; chip erase restores
// - general write lock does not affect store_program_op programming
// - general read/write lock does not restrict load or store requests
// - application locks both 1: no restriction on application accesses
// - app_write_lock 0: store writes to application section rejected
// - app_read_lock 0: loads of application section from loader section blocked
// - app_read_lock 0, vectors in loader: interrupts off while running application
// - boot locks both 1: no restriction on loader section accesses
// - boot_write_lock 0: store writes to loader section rejected
// - boot_read_lock 0: loads of loader section from application blocked
// - boot_read_lock 0, vectors in application: interrupts off while running loader
// - boot_reset_select 1: reset vector is address zero
// - boot_reset_select 0: reset vector is loader section start
// - core has no path to modify fuses; fuses are pins only
// - store requests act only when executed from the loader section
// - concurrent_region_busy reads one while the concurrent region is blocked
module bfp_protect
    import bfp_pkg::*;
#(
    parameter int AW = FLASH_AW,
    parameter logic [AW-1:0] HALT_START = HALT_REGION_START
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // fuse pins from the programming interface
    input wire logic [1:0] boot_size_select_in,
    input wire logic boot_reset_select_in,
    // nonvolatile lock image and external programming
    input wire logic [LOCK_W-1:0] lock_init_in,
    input wire logic ext_lock_prog_in,
    input wire logic [LOCK_W-1:0] ext_lock_data_in,
    input wire logic chip_erase_in,
    // core side
    input wire logic req_valid_in,
    input wire bfp_req_type req_kind_in,
    input wire logic [AW-1:0] req_addr_in,
    input wire logic [AW-1:0] exec_addr_in,
    input wire logic [LOCK_W-1:0] req_lock_data_in,
    input wire logic ivec_in_boot_in,
    output logic grant_out,
    output logic reject_out,
    output logic core_halt_out,
    output logic concurrent_region_busy_out,
    output logic irq_suppress_out,
    output logic [AW-1:0] reset_vector_out,
    output logic [LOCK_W-1:0] lock_bits_out,
    // flash array side
    input wire logic flash_done_in,
    output logic flash_start_out,
    output logic flash_erase_out,
    output logic [AW-1:0] flash_addr_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONC_OP, ST_HALT_OP} bfp_state_type;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        bfp_state_type state;
        logic loaded;
        logic [LOCK_W-1:0] lock;
        logic busy;
        logic halt;
        logic start;
        logic erase;
        logic [AW-1:0] addr;
        logic grant;
        logic reject;
        logic irq_sup;
        logic [AW-1:0] rst_vec;
    } bfp_ctl_type;

    bfp_ctl_type s_r;
    bfp_ctl_type s_nxt;
    logic rst_n;
    logic [FUSE_W-1:0] fuse_sync;
    logic [AW-1:0] boot_words;
    logic [AW-1:0] boot_start;
    logic req_boot;
    logic req_halting;
    logic exec_boot;
    logic exec_halting;
    logic is_flash_write;
    logic write_ok;
    logic load_ok;

    assign rst_n = s_r.rst_sync;

    // ------------------------------------------------------------
    // fuse pins and section boundaries
    // ------------------------------------------------------------
    // fuses arrive only as pins; no core request reaches them
    bfp_sync #(
        .WIDTH(FUSE_W)
    ) u_fuse_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .d_in({boot_reset_select_in, boot_size_select_in}),
        .q_out(fuse_sync)
    );

    // loader section size from the boot size code
    always_comb begin
        unique case (fuse_sync[1:0])
            2'h0: boot_words = BOOT_WORDS_SEL0;
            2'h1: boot_words = BOOT_WORDS_SEL1;
            2'h2: boot_words = BOOT_WORDS_SEL2;
            2'h3: boot_words = BOOT_WORDS_SEL3;
        endcase
        boot_start = AW'(~boot_words + 1'b1); // top of flash minus size
    end

    bfp_section #(
        .AW(AW)
    ) u_req_sec (
        .addr_in(req_addr_in),
        .boot_start_in(boot_start),
        .halt_start_in(HALT_START),
        .in_boot_out(req_boot),
        .in_halting_out(req_halting)
    );

    bfp_section #(
        .AW(AW)
    ) u_exec_sec (
        .addr_in(exec_addr_in),
        .boot_start_in(boot_start),
        .halt_start_in(HALT_START),
        .in_boot_out(exec_boot),
        .in_halting_out(exec_halting)
    );

    // ------------------------------------------------------------
    // access decisions
    // ------------------------------------------------------------
    // only the section lock bits are consulted, never a general lock
    always_comb begin
        is_flash_write = (req_kind_in == BFP_REQ_ERASE) || (req_kind_in == BFP_REQ_WRITE);
        write_ok = req_boot ? s_r.lock[LOCK_BOOT_WRITE]
                            : s_r.lock[LOCK_APP_WRITE];
        load_ok = 1'b1;
        if (!req_boot && exec_boot && !s_r.lock[LOCK_APP_READ]) begin
            load_ok = 1'b0;
        end
        if (req_boot && !exec_boot && !s_r.lock[LOCK_BOOT_READ]) begin
            load_ok = 1'b0;
        end
        if (s_r.busy && !req_halting) begin
            load_ok = 1'b0; // concurrent region blocked
        end
        if (s_r.state == ST_HALT_OP) begin
            load_ok = 1'b0; // nothing readable
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_meta = 1'b1;
        s_nxt.rst_sync = s_r.rst_meta;
        s_nxt.start = 1'b0;
        s_nxt.grant = 1'b0;
        s_nxt.reject = 1'b0;
        // lock image taken once after reset release
        if (!s_r.loaded) begin
            s_nxt.lock = lock_init_in;
            s_nxt.loaded = 1'b1;
        end
        // programming only clears bits toward 0
        if (ext_lock_prog_in) begin
            s_nxt.lock = s_nxt.lock & ext_lock_data_in;
        end
        // operation end
        if (s_r.state != ST_IDLE && flash_done_in) begin
            s_nxt.state = ST_IDLE;
        end
        // core requests
        if (req_valid_in) begin
            if (req_kind_in == BFP_REQ_LOAD) begin
                s_nxt.grant = load_ok;
                s_nxt.reject = !load_ok;
            end else if (!exec_boot || s_r.state != ST_IDLE) begin
                s_nxt.reject = 1'b1; // store ignored outside loader
            end else if (is_flash_write) begin
                if (write_ok) begin
                    s_nxt.start = 1'b1;
                    s_nxt.grant = 1'b1;
                    s_nxt.erase = (req_kind_in == BFP_REQ_ERASE);
                    s_nxt.addr = req_addr_in;
                    if (req_halting) begin
                        s_nxt.state = ST_HALT_OP;
                    end else begin
                        s_nxt.state = ST_CONC_OP;
                        s_nxt.busy = 1'b1;
                    end
                end else begin
                    s_nxt.reject = 1'b1;
                end
            end else if (req_kind_in == BFP_REQ_LOCK_SET) begin
                s_nxt.lock = s_nxt.lock & req_lock_data_in;
                s_nxt.grant = 1'b1;
            end else if (req_kind_in == BFP_REQ_REGION_ENABLE) begin
                s_nxt.busy = 1'b0; // unblocked only after the operation
                s_nxt.grant = 1'b1;
            end else begin
                s_nxt.grant = 1'b1; // page buffer fill
            end
        end
        // chip erase is the only way back to unprogrammed
        if (chip_erase_in) begin
            s_nxt.lock = LOCK_ERASED;
        end
        s_nxt.halt = (s_nxt.state == ST_HALT_OP);
        // interrupt suppression by section and vector placement
        s_nxt.irq_sup = (!s_r.lock[LOCK_APP_READ] && ivec_in_boot_in && !exec_boot)
            || (!s_r.lock[LOCK_BOOT_READ] && !ivec_in_boot_in && exec_boot);
        // reset vector from the boot reset fuse
        s_nxt.rst_vec = fuse_sync[FUSE_BOOT_RESET] ? APP_RESET_ADDR
                                                   : boot_start;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
            s_r.state <= ST_IDLE;
            s_r.lock <= LOCK_ERASED;
            s_r.rst_vec <= APP_RESET_ADDR;
        end else if (!s_r.rst_sync) begin
            s_r.rst_meta <= s_nxt.rst_meta;
            s_r.rst_sync <= s_nxt.rst_sync;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign grant_out = s_r.grant;
    assign reject_out = s_r.reject;
    assign core_halt_out = s_r.halt;
    assign concurrent_region_busy_out = s_r.busy;
    assign irq_suppress_out = s_r.irq_sup;
    assign reset_vector_out = s_r.rst_vec;
    assign lock_bits_out = s_r.lock;
    assign flash_start_out = s_r.start;
    assign flash_erase_out = s_r.erase;
    assign flash_addr_out = s_r.addr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n || !s_r.loaded);

    sequence seq_store_from_app;
        req_valid_in && req_kind_in != BFP_REQ_LOAD && !exec_boot;
    endsequence

    sequence seq_locked_app_write;
        req_valid_in && is_flash_write && exec_boot && s_r.state == ST_IDLE
            && !req_boot && !s_r.lock[LOCK_APP_WRITE];
    endsequence

    sequence seq_locked_boot_write;
        req_valid_in && is_flash_write && exec_boot && s_r.state == ST_IDLE
            && req_boot && !s_r.lock[LOCK_BOOT_WRITE];
    endsequence

    sequence seq_halt_start;
        req_valid_in && is_flash_write && exec_boot && s_r.state == ST_IDLE
            && write_ok && req_halting;
    endsequence

    AST_STORE_FROM_APP: assert property (seq_store_from_app |=> reject_out && !flash_start_out)
        else $error("store from application section was acted on");
    AST_APP_WRITE_LOCK: assert property (seq_locked_app_write |=> reject_out && !flash_start_out)
        else $error("locked application write started");
    AST_BOOT_WRITE_LOCK: assert property (seq_locked_boot_write |=> reject_out && !flash_start_out)
        else $error("locked loader write started");
    AST_HALT_DURING_OP: assert property (seq_halt_start |=>
        core_halt_out && flash_start_out ##1 (core_halt_out && !grant_out) [*1])
        else $error("core not halted for halting region operation");
    AST_BUSY_HELD: assert property (s_r.state == ST_CONC_OP |->
        concurrent_region_busy_out && !core_halt_out)
        else $error("busy flag low or core halted during concurrent operation");
    // a locked application read from the loader is still refused, so leave it out here
    AST_HALTING_READ: assert property (req_valid_in && req_kind_in == BFP_REQ_LOAD
        && s_r.state == ST_CONC_OP && req_halting && !req_boot
        && (s_r.lock[LOCK_APP_READ] || !exec_boot) |=> grant_out)
        else $error("halting region read refused during concurrent operation");
    AST_APP_READ_LOCK: assert property (req_valid_in && req_kind_in == BFP_REQ_LOAD
        && exec_boot && !req_boot && !s_r.lock[LOCK_APP_READ] |=> reject_out && !grant_out)
        else $error("locked application read granted");
    AST_BOOT_READ_LOCK: assert property (req_valid_in && req_kind_in == BFP_REQ_LOAD
        && !exec_boot && req_boot && !s_r.lock[LOCK_BOOT_READ] |=> reject_out)
        else $error("locked loader read granted");
    AST_LOCK_ONE_WAY: assert property (!chip_erase_in |=> (lock_bits_out
        & ~$past(lock_bits_out)) == '0)
        else $error("lock bit returned to unprogrammed without chip erase");
    AST_RESET_VECTOR: assert property (##1 reset_vector_out ==
        ($past(fuse_sync[FUSE_BOOT_RESET]) ? APP_RESET_ADDR : $past(boot_start)))
        else $error("reset vector does not follow boot reset fuse");
    AST_IRQ_APP: assert property (!s_r.lock[LOCK_APP_READ] && ivec_in_boot_in
        && !exec_boot |=> irq_suppress_out)
        else $error("interrupts not suppressed in application");
    AST_IRQ_BOOT: assert property (!s_r.lock[LOCK_BOOT_READ] && !ivec_in_boot_in
        && exec_boot |=> irq_suppress_out)
        else $error("interrupts not suppressed in loader");

endmodule : bfp_protect

// file: dv/bfp_flash_model.sv
`timescale 1ns/1ps
// flash array stand-in: each start is answered after a delay chosen by the bench
module bfp_flash_model
    import bfp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic erase_in,
    input wire logic [FLASH_AW-1:0] addr_in,
    input wire logic [7:0] delay_in,
    output logic done_out,
    output logic active_out,
    output logic [15:0] op_count_out,
    output logic [FLASH_AW-1:0] last_addr_out,
    output logic last_erase_out
);
    logic [7:0] cnt_r;

    // ----------------------------------------------------------------
    // operation timing
    // ----------------------------------------------------------------
    // latch the page operation, count down, then pulse done once
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            active_out <= 1'b0;
            op_count_out <= 16'h0000;
            cnt_r <= 8'h00;
        end else begin
            done_out <= 1'b0;
            if (start_in && !active_out) begin
                active_out <= 1'b1;
                cnt_r <= delay_in;
                op_count_out <= op_count_out + 16'h0001;
                last_addr_out <= addr_in;
                last_erase_out <= erase_in;
            end else if (active_out) begin
                if (cnt_r == 8'h00) begin
                    done_out <= 1'b1; // one op at a time, done ends it
                    active_out <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule : bfp_flash_model

// file: dv/boot_flash_protection_test.sv
`timescale 1ns/1ps
module boot_flash_protection_test
    import bfp_pkg::*;
;
    localparam logic [13:0] LDR = 14'h3f00; // loader start for size code 3
    logic clk_in = 1'b0;
    logic rst_n_in, boot_reset_select_in, ext_lock_prog_in, chip_erase_in, req_valid_in;
    logic ivec_in_boot_in, grant_out, reject_out, core_halt_out, busy, irq_suppress_out;
    logic flash_done_in, flash_start_out, flash_erase_out, f_active, f_erase;
    logic [1:0] boot_size_select_in;
    logic [3:0] lock_init_in, ext_lock_data_in, req_lock_data_in, lock_bits_out, d;
    logic [13:0] req_addr_in, exec_addr_in, reset_vector_out, flash_addr_out, f_addr;
    logic [15:0] f_count;
    logic [7:0] flash_delay;
    logic [31:0] seed = 32'h0000_0014;
    logic [31:0] r;
    logic [1:0] modes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    bfp_req_type req_kind_in;
    logic exp_q [$];
    logic exp_ok;
    int bad_count = 0;
    int checked = 0;

    bfp_protect i_bfp_protect (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .boot_size_select_in(boot_size_select_in), .boot_reset_select_in(boot_reset_select_in),
        .lock_init_in(lock_init_in), .ext_lock_prog_in(ext_lock_prog_in),
        .ext_lock_data_in(ext_lock_data_in), .chip_erase_in(chip_erase_in),
        .req_valid_in(req_valid_in), .req_kind_in(req_kind_in), .req_addr_in(req_addr_in),
        .exec_addr_in(exec_addr_in), .req_lock_data_in(req_lock_data_in),
        .ivec_in_boot_in(ivec_in_boot_in), .grant_out(grant_out), .reject_out(reject_out),
        .core_halt_out(core_halt_out), .concurrent_region_busy_out(busy),
        .irq_suppress_out(irq_suppress_out), .reset_vector_out(reset_vector_out),
        .lock_bits_out(lock_bits_out), .flash_done_in(flash_done_in),
        .flash_start_out(flash_start_out), .flash_erase_out(flash_erase_out),
        .flash_addr_out(flash_addr_out));
    bfp_flash_model i_bfp_flash_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .start_in(flash_start_out), .erase_in(flash_erase_out), .addr_in(flash_addr_out),
        .delay_in(flash_delay), .done_out(flash_done_in), .active_out(f_active),
        .op_count_out(f_count), .last_addr_out(f_addr), .last_erase_out(f_erase));

    always #4 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // one core request; the expected answer goes to the scoreboard
    task automatic req(input bfp_req_type k, input logic [13:0] a, input logic [13:0] x,
                       input logic ok);
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_kind_in <= k;
        req_addr_in <= a;
        exec_addr_in <= x;
        exp_q.push_back(ok);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : req

    task automatic do_reset(input logic boot_reset_select, input logic [1:0] sz, input logic [3:0] init);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        boot_reset_select_in <= boot_reset_select;
        boot_size_select_in <= sz;
        lock_init_in <= init;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask : do_reset

    // chip erase pulse, or external programming of the lock image
    task automatic pulse_lock(input logic erase, input logic [3:0] data);
        @(posedge clk_in);
        chip_erase_in <= erase;
        ext_lock_prog_in <= !erase;
        ext_lock_data_in <= data;
        @(posedge clk_in);
        chip_erase_in <= 1'b0;
        ext_lock_prog_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : pulse_lock

    // wait out the array, then reopen the concurrent region from the loader
    task automatic finish_op();
        for (int i = 0; i < 300 && f_active; i++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
        req(BFP_REQ_REGION_ENABLE, 14'h0000, LDR, 1'b1);
    endtask : finish_op

    // scoreboard: every answer pulse takes the oldest expectation
    always @(posedge clk_in) begin
        if (grant_out === 1'b1 || reject_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected answer", 16'h0001, 16'h0000);
            end else begin
                exp_ok = exp_q.pop_front();
                check("grant", 16'(grant_out), 16'(exp_ok));
                check("reject", 16'(reject_out), 16'(!exp_ok));
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        test_done();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        boot_reset_select_in = 1'b1;
        boot_size_select_in = 2'h3;
        lock_init_in = 4'hf;
        ext_lock_prog_in = 1'b0;
        ext_lock_data_in = 4'hf;
        chip_erase_in = 1'b0;
        req_valid_in = 1'b0;
        req_kind_in = BFP_REQ_LOAD;
        req_addr_in = 14'h0000;
        exec_addr_in = 14'h0000;
        req_lock_data_in = 4'hf;
        ivec_in_boot_in = 1'b0;
        flash_delay = 8'h00;
        for (int k = 0; k < 4; k++) begin
            do_reset(1'b0, 2'(k), 4'hf);
            check("boot vector", 16'(reset_vector_out), 16'h4000 - (16'h0800 >> k));
        end
        do_reset(1'b1, 2'h3, 4'h5);
        check("app vector", 16'(reset_vector_out), 16'h0000);
        check("lock image", 16'(lock_bits_out), 16'h0005);
        do_reset(1'b0, 2'h3, 4'hf);
        $display("test reset done");
        // unlocked loads across both sections at random addresses
        for (int i = 0; i < 8; i++) begin
            r = xs();
            req(BFP_REQ_LOAD, 14'(r[13:0] % 14'h3f00), LDR + 14'h0010, 1'b1);
            req(BFP_REQ_LOAD, LDR | 14'(r[7:0]), 14'h0100, 1'b1);
        end
        // stores count only when executed from the loader
        req(BFP_REQ_FILL, 14'h0040, 14'h0100, 1'b0);
        req(BFP_REQ_ERASE, 14'h0040, LDR - 14'h0001, 1'b0);
        req(BFP_REQ_LOCK_SET, 14'h0000, 14'h3800, 1'b0);
        check("ops started", f_count, 16'h0000);
        req(BFP_REQ_FILL, 14'h0040, LDR, 1'b1);
        $display("test access done");
        // concurrent region erase: core runs, only the halting region reads
        flash_delay <= 8'd20;
        req(BFP_REQ_ERASE, 14'h0200, LDR, 1'b1);
        check("array addr", 16'(f_addr), 16'h0200);
        check("array erase", 16'(f_erase), 16'h0001);
        check("halt", 16'(core_halt_out), 16'h0000);
        check("busy", 16'(busy), 16'h0001);
        req(BFP_REQ_LOAD, 14'h3810, LDR, 1'b1);
        req(BFP_REQ_LOAD, 14'h0300, LDR, 1'b0);
        for (int i = 0; i < 300 && f_active; i++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
        check("busy after", 16'(busy), 16'h0001);
        req(BFP_REQ_REGION_ENABLE, 14'h0000, LDR, 1'b1);
        check("busy cleared", 16'(busy), 16'h0000);
        req(BFP_REQ_LOAD, 14'h0300, LDR, 1'b1);
        // halting region write: core stops, nothing readable
        flash_delay <= 8'd40;
        req(BFP_REQ_WRITE, 14'h3850, LDR, 1'b1);
        check("halt", 16'(core_halt_out), 16'h0001);
        check("array write", 16'(f_erase), 16'h0000);
        req(BFP_REQ_LOAD, 14'h3f20, LDR, 1'b0);
        req(BFP_REQ_LOAD, 14'h0010, LDR, 1'b0);
        finish_op();
        check("halt end", 16'(core_halt_out), 16'h0000);
        $display("test programming done");
        // software lock setting never unprograms a bit
        r = xs();
        req_lock_data_in <= r[3:0];
        req(BFP_REQ_LOCK_SET, 14'h0000, LDR, 1'b1);
        check("lock set", 16'(lock_bits_out), 16'(r[3:0]));
        req_lock_data_in <= 4'hf;
        req(BFP_REQ_LOCK_SET, 14'h0000, LDR, 1'b1);
        check("lock kept", 16'(lock_bits_out), 16'(r[3:0]));
        // every protection mode of both sections
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                d = s == 0 ? {modes[m], 2'b11} : {2'b11, modes[m]};
                pulse_lock(1'b1, 4'h0);
                pulse_lock(1'b0, d);
                check("lock mode", 16'(lock_bits_out), 16'(d));
                flash_delay <= 8'(xs() & 32'h0000_000f);
                req(BFP_REQ_WRITE, s == 0 ? 14'h3850 : 14'h3f40, LDR, modes[m][0]);
                if (modes[m][0]) finish_op();
                req(BFP_REQ_LOAD, s == 0 ? 14'h3850 : 14'h3f40,
                    s == 0 ? LDR : 14'h0100, modes[m][1]);
                exec_addr_in <= s == 0 ? 14'h0100 : LDR;
                ivec_in_boot_in <= s == 0;
                repeat (3) @(posedge clk_in);
                check("irq off", 16'(irq_suppress_out), 16'(!modes[m][1]));
                ivec_in_boot_in <= s != 0;
                repeat (3) @(posedge clk_in);
                check("irq kept", 16'(irq_suppress_out), 16'h0000);
            end
        end
        pulse_lock(1'b1, 4'h0);
        check("chip erase", 16'(lock_bits_out), 16'h000f);
        $display("test lock modes done");
        repeat (4) @(posedge clk_in);
        check("answers pending", 16'(exp_q.size()), 16'h0000);
        test_done();
    end
endmodule : boot_flash_protection_test
